// file: rtl/dspc_pkg.sv
// Shared constants, field layouts and types for the DSP core status block
package dspc_pkg;

	// Data and operand widths, stack depth and pipeline stage count
	localparam int DSPC_WORD_W  = 16;
	localparam int DSPC_PROD_W  = 32;
	localparam int DSPC_STK_DEP = 8;
	localparam int DSPC_ARP_W   = 3;
	localparam int DSPC_DP_W    = 9;
	localparam int DSPC_DIR_W   = 7;
	localparam int DSPC_BIT_W   = 4;
	localparam int DSPC_PIPE_N  = 4;

	// Status word zero field positions
	localparam int ST0_ARP_HI  = 15;
	localparam int ST0_ARP_LO  = 13;
	localparam int ST0_OV_BIT  = 12;
	localparam int ST0_OVM_BIT = 11;
	localparam int ST0_GLOBAL_INTERRUPT_MASK_BIT    = 9;
	localparam int ST0_DP_HI   = 8;
	localparam int ST0_DP_LO   = 0;

	// Status word one field positions
	localparam int ST1_ARB_HI  = 15;
	localparam int ST1_ARB_LO  = 13;
	localparam int ST1_CNF     = 12;
	localparam int ST1_TC_BIT  = 11;
	localparam int ST1_SXM_BIT = 10;
	localparam int ST1_CARRY   = 9;
	localparam int ST1_XF_BIT  = 4;
	localparam int ST1_PM_HI   = 1;
	localparam int ST1_PM_LO   = 0;

	// Reserved positions, always read back as ones; then the mask bit and page field masks
	localparam logic [15:0] ST0_RSVD_MASK = 16'h0400;
	localparam logic [15:0] ST1_RSVD_MASK = 16'h01EC;
	localparam logic [15:0] ST0_GLOBAL_INTERRUPT_MASK_BIT_MASK = 16'h0200;
	localparam logic [15:0] ST0_DP_MASK   = 16'h01FF;

	// Reset images: carry, mask, sign-extension and flag pin set; mapping bit clear
	localparam logic [15:0] ST0_RESET = 16'h0600;
	localparam logic [15:0] ST1_RESET = 16'h07FC;

	// Dual-access RAM block windows
	localparam logic [15:0] B1_DATA_LO = 16'h0300;
	localparam logic [15:0] B1_DATA_HI = 16'h03FF;
	localparam logic [15:0] B2_DATA_LO = 16'h0060;
	localparam logic [15:0] B2_DATA_HI = 16'h007F;

	// Product shift amounts
	localparam int PM_SHL_ONE  = 1;
	localparam int PM_SHL_FOUR = 4;
	localparam int PM_SHR_SIX  = 6;

	// Product shift modes
	typedef enum logic [1:0] {
		PM_NONE   = 2'b00,
		PM_LEFT1  = 2'b01,
		PM_LEFT4  = 2'b10,
		PM_RIGHT6 = 2'b11
	} dspc_pm_e;

	// Status word selector for set/clear control-bit instructions
	typedef enum logic {
		SEL_ST0 = 1'b0,
		SEL_ST1 = 1'b1
	} dspc_stsel_e;

endpackage

// file: rtl/dspc_stack_if.sv
// Carrier between the stack controller and the stack memory
`timescale 1ns/100ps
interface dspc_stack_if #(
	parameter int DEPTH = 8,
	parameter int WIDTH = 16
);
	localparam int AW = $clog2(DEPTH);

	logic             wr_en;
	logic [AW-1:0]    wr_addr;
	logic [WIDTH-1:0] wr_data;
	logic [AW-1:0]    rd_addr;
	logic [WIDTH-1:0] rd_data;

	modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr,
		input rd_data);
	modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr,
		output rd_data);
endinterface

// file: rtl/dspc_stack_mem.sv
// Hardware stack storage with registered, write-through read port
`timescale 1ns/100ps
module dspc_stack_mem #(
	parameter int DEPTH = 8,
	parameter int WIDTH = 16
) (
	input  wire logic i_clk,
	input  wire logic i_rst,
	dspc_stack_if.mem port
);
	logic [WIDTH-1:0] mem_reg [DEPTH];

	// Storage array; no reset since contents are undefined until pushed
	always_ff @(posedge i_clk)
	begin
		if (port.wr_en)
		begin
			mem_reg[port.wr_addr] <= port.wr_data;
		end
	end

	// Read register forwards a same-cycle write so the top never lags a push
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			port.rd_data <= '0;
		end
		else if (port.wr_en && (port.wr_addr == port.rd_addr))
		begin
			port.rd_data <= port.wr_data;
		end
		else
		begin
			port.rd_data <= mem_reg[port.rd_addr];
		end
	end
endmodule

// file: rtl/dspc_status_regs.sv
// Core status words, product path, operand register and hardware stack
`timescale 1ns/100ps
module dspc_status_regs
	import dspc_pkg::*;
#(
	parameter int          STK_DEPTH  = dspc_pkg::DSPC_STK_DEP,
	parameter logic [15:0] B0_DATA_LO = 16'h0200,
	parameter logic [15:0] B0_DATA_HI = 16'h02FF,
	parameter logic [15:0] B0_PROG_LO = 16'hFF00,
	parameter logic [15:0] B0_PROG_HI = 16'hFFFF
) (
	input  wire logic                          i_clk,
	input  wire logic                          i_rst,
	input  wire logic                          i_fetch_valid,
	input  wire logic                          i_lst0_valid,
	input  wire logic                          i_lst1_valid,
	input  wire logic [dspc_pkg::DSPC_WORD_W-1:0] i_lst_data,
	input  wire logic                          i_ctl_valid,
	input  wire logic                          i_ctl_set,
	input  wire dspc_pkg::dspc_stsel_e         i_ctl_sel,
	input  wire logic [dspc_pkg::DSPC_BIT_W-1:0]  i_ctl_bit,
	input  wire logic                          i_arp_valid,
	input  wire logic [dspc_pkg::DSPC_ARP_W-1:0]  i_arp_data,
	input  wire logic                          i_ldp_valid,
	input  wire logic [dspc_pkg::DSPC_DP_W-1:0]   i_ldp_data,
	input  wire logic [dspc_pkg::DSPC_DIR_W-1:0]  i_dir_lsbs,
	input  wire logic                          i_alu_valid,
	input  wire logic                          i_alu_sub,
	input  wire logic                          i_alu_shift16,
	input  wire logic                          i_alu_cout,
	input  wire logic                          i_shift_valid,
	input  wire logic                          i_shift_cout,
	input  wire logic                          i_interrupt_acknowledge,
	input  wire logic                          i_trap_maskable,
	input  wire logic                          i_int_req,
	input  wire logic                          i_nmi_req,
	input  wire logic                          i_multiplier_operand_register_load,
	input  wire logic [dspc_pkg::DSPC_WORD_W-1:0] i_multiplier_operand_register_data,
	input  wire logic                          i_mpy_valid,
	input  wire logic                          i_mpy_unsigned,
	input  wire logic [dspc_pkg::DSPC_WORD_W-1:0] i_mpy_operand,
	input  wire logic                          i_push,
	input  wire logic                          i_pop,
	input  wire logic [dspc_pkg::DSPC_WORD_W-1:0] i_push_data,
	input  wire logic [dspc_pkg::DSPC_WORD_W-1:0] i_data_addr,
	input  wire logic [dspc_pkg::DSPC_WORD_W-1:0] i_prog_addr,
	output logic      [dspc_pkg::DSPC_WORD_W-1:0] o_st0,
	output logic      [dspc_pkg::DSPC_WORD_W-1:0] o_st1,
	output logic      [dspc_pkg::DSPC_WORD_W-1:0] o_direct_addr,
	output logic                               o_int_take,
	output logic      [dspc_pkg::DSPC_WORD_W-1:0] o_multiplier_operand_register,
	output logic      [dspc_pkg::DSPC_BIT_W-1:0]  o_shift_count,
	output logic      [dspc_pkg::DSPC_BIT_W-1:0]  o_bit_index,
	output logic      [dspc_pkg::DSPC_PROD_W-1:0] o_product,
	output logic      [dspc_pkg::DSPC_PROD_W-1:0] o_pscaled,
	output logic      [dspc_pkg::DSPC_WORD_W-1:0] o_stack_top,
	output logic                               o_b0_data_hit,
	output logic                               o_b0_prog_hit,
	output logic                               o_b1_hit,
	output logic                               o_b2_hit,
	output logic                               o_exec_valid
);
	import dspc_pkg::*;

	localparam int SP_W = $clog2(STK_DEPTH);

	logic [15:0]            st0_reg;
	logic [15:0]            st0_next;
	logic [15:0]            st1_reg;
	logic [15:0]            st1_next;
	logic [31:0]            product_holding_register_next;
	logic [15:0]            multiplier_operand_register_next;
	logic [SP_W-1:0]        sp_reg;
	logic [SP_W-1:0]        sp_next;
	logic [DSPC_PIPE_N-1:0] pipe_reg;
	logic                   ctl_in_dp;

	dspc_stack_if #(.DEPTH(STK_DEPTH), .WIDTH(DSPC_WORD_W)) stk ();

	// Inclusive address window compare, shared by all block decoders
	function automatic logic in_window(input logic [15:0] a, input logic [15:0] lo,
		input logic [15:0] hi);
		in_window = (a >= lo) && (a <= hi);
	endfunction

	// Product scaling sits on the read path only; the stored product stays raw
	function automatic logic [31:0] product_scaling_shifter(input logic [31:0] p, input dspc_pm_e m);
		case (m)
			PM_NONE:   product_scaling_shifter = p;
			PM_LEFT1:  product_scaling_shifter = p << PM_SHL_ONE;
			PM_LEFT4:  product_scaling_shifter = p << PM_SHL_FOUR;
			PM_RIGHT6: product_scaling_shifter = 32'($signed(p) >>> PM_SHR_SIX);
			default:   product_scaling_shifter = p;
		endcase
	endfunction

	// The page pointer is reserved for load-status and load-page alone
	assign ctl_in_dp = (i_ctl_sel == SEL_ST0) && (int'(i_ctl_bit) <= ST0_DP_HI);

	// Next value of status word zero
	always_comb
	begin
		st0_next = st0_reg;
		if (i_lst0_valid)
		begin
			st0_next = (i_lst_data & ~ST0_GLOBAL_INTERRUPT_MASK_BIT_MASK) | (st0_reg & ST0_GLOBAL_INTERRUPT_MASK_BIT_MASK);
		end
		if (i_lst1_valid)
		begin
			st0_next[ST0_ARP_HI:ST0_ARP_LO] = i_lst_data[ST1_ARB_HI:ST1_ARB_LO];
		end
		else if (i_arp_valid)
		begin
			st0_next[ST0_ARP_HI:ST0_ARP_LO] = i_arp_data;
		end
		if (i_ldp_valid)
		begin
			st0_next[ST0_DP_HI:ST0_DP_LO] = i_ldp_data;
		end
		if (i_ctl_valid && (i_ctl_sel == SEL_ST0) && !ctl_in_dp)
		begin
			st0_next[i_ctl_bit] = i_ctl_set;
		end
		// Hardware set of the mask outranks a clear in the same cycle
		if (i_interrupt_acknowledge || i_trap_maskable)
		begin
			st0_next[ST0_GLOBAL_INTERRUPT_MASK_BIT] = 1'b1;
		end
		st0_next = st0_next | ST0_RSVD_MASK;
	end

	// Next value of status word one
	always_comb
	begin
		st1_next = st1_reg;
		if (i_lst1_valid)
		begin
			st1_next = i_lst_data;
		end
		else if (i_arp_valid && !i_lst0_valid)
		begin
			st1_next[ST1_ARB_HI:ST1_ARB_LO] = st0_reg[ST0_ARP_HI:ST0_ARP_LO];
		end
		// Arithmetic carry; i_alu_cout means carry on add, borrow on subtract
		if (i_alu_valid && !i_alu_shift16)
		begin
			st1_next[ST1_CARRY] = i_alu_sub ? ~i_alu_cout : i_alu_cout;
		end
		else if (i_alu_valid && i_alu_cout)
		begin
			st1_next[ST1_CARRY] = ~i_alu_sub;
		end
		if (i_shift_valid)
		begin
			st1_next[ST1_CARRY] = i_shift_cout;
		end
		if (i_ctl_valid && (i_ctl_sel == SEL_ST1))
		begin
			st1_next[i_ctl_bit] = i_ctl_set;
		end
		st1_next = st1_next | ST1_RSVD_MASK;
	end

	// Status registers; reset sets carry and mask, clears mapping bit
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			st0_reg <= ST0_RESET;
			st1_reg <= ST1_RESET;
		end
		else
		begin
			st0_reg <= st0_next;
			st1_reg <= st1_next;
		end
	end

	// Store-status view; taken from the register so a read sees settled state
	assign o_st0 = st0_reg;
	assign o_st1 = st1_reg;

	// Direct address built from the updated page so the next access sees it
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_direct_addr <= '0;
		end
		else
		begin
			o_direct_addr <= {st0_next[ST0_DP_HI:ST0_DP_LO], i_dir_lsbs};
		end
	end

	// Interrupt acceptance; the non-maskable request bypasses the mask
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_int_take <= 1'b0;
		end
		else
		begin
			o_int_take <= (i_int_req && !st0_reg[ST0_GLOBAL_INTERRUPT_MASK_BIT]) || i_nmi_req;
		end
	end

	// Operand register and the counts it feeds to the shifter and bit test
	assign multiplier_operand_register_next = i_multiplier_operand_register_load ? i_multiplier_operand_register_data : o_multiplier_operand_register;

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_multiplier_operand_register        <= '0;
			o_shift_count <= '0;
			o_bit_index   <= '0;
		end
		else
		begin
			o_multiplier_operand_register        <= multiplier_operand_register_next;
			o_shift_count <= multiplier_operand_register_next[DSPC_BIT_W-1:0];
			o_bit_index   <= multiplier_operand_register_next[DSPC_BIT_W-1:0];
		end
	end

	// Full-width product of the held operand and the incoming one
	always_comb
	begin
		product_holding_register_next = o_product;
		if (i_mpy_valid && i_mpy_unsigned)
		begin
			product_holding_register_next = {16'h0000, o_multiplier_operand_register} * {16'h0000, i_mpy_operand};
		end
		else if (i_mpy_valid)
		begin
			// Operands widened first so the low 32 bits hold the signed product
			product_holding_register_next = {{16{o_multiplier_operand_register[15]}}, o_multiplier_operand_register} * {{16{i_mpy_operand[15]}}, i_mpy_operand};
		end
	end

	// Scaled copy follows both product and mode in the same cycle: no extra stage
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_product <= '0;
			o_pscaled <= '0;
		end
		else
		begin
			o_product <= product_holding_register_next;
			o_pscaled <= product_scaling_shifter(product_holding_register_next, dspc_pm_e'(st1_next[ST1_PM_HI:ST1_PM_LO]));
		end
	end

	// Stack pointer; overflow wraps and overwrites the oldest entry
	always_comb
	begin
		sp_next = sp_reg;
		if (i_push && !i_pop)
		begin
			sp_next = SP_W'(sp_reg + 1'b1);
		end
		else if (i_pop && !i_push)
		begin
			sp_next = SP_W'(sp_reg - 1'b1);
		end
	end

	// Push with pop in one cycle replaces the top entry
	assign stk.wr_en   = i_push;
	assign stk.wr_addr = i_pop ? SP_W'(sp_reg - 1'b1) : sp_reg;
	assign stk.wr_data = i_push_data;
	assign stk.rd_addr = SP_W'(sp_next - 1'b1);

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			sp_reg <= '0;
		end
		else
		begin
			sp_reg <= sp_next;
		end
	end

	dspc_stack_mem #(
		.DEPTH (STK_DEPTH),
		.WIDTH (DSPC_WORD_W)
	) u_stack (
		.i_clk (i_clk),
		.i_rst (i_rst),
		.port  (stk.mem)
	);

	assign o_stack_top = stk.rd_data;

	// Program and data ports decoded side by side so fetch and read overlap
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_b0_data_hit <= 1'b0;
			o_b0_prog_hit <= 1'b0;
			o_b1_hit      <= 1'b0;
			o_b2_hit      <= 1'b0;
		end
		else
		begin
			o_b0_data_hit <= !st1_next[ST1_CNF] && in_window(i_data_addr, B0_DATA_LO, B0_DATA_HI);
			o_b0_prog_hit <= st1_next[ST1_CNF] && in_window(i_prog_addr, B0_PROG_LO, B0_PROG_HI);
			o_b1_hit      <= in_window(i_data_addr, B1_DATA_LO, B1_DATA_HI);
			o_b2_hit      <= in_window(i_data_addr, B2_DATA_LO, B2_DATA_HI);
		end
	end

	// Fetch, decode, operand and execute stages, one instruction per clock
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			pipe_reg <= '0;
		end
		else
		begin
			pipe_reg <= {pipe_reg[DSPC_PIPE_N-2:0], i_fetch_valid};
		end
	end

	assign o_exec_valid = pipe_reg[DSPC_PIPE_N-1];
endmodule

// file: sim/dspc_status_regs_chk.sv
// Port-level assertions for the core status block
`timescale 1ns/100ps
module dspc_status_regs_chk
	import dspc_pkg::*;
(
	input logic        i_clk,
	input logic        i_rst,
	input logic        i_fetch_valid,
	input logic        i_lst0_valid,
	input logic        i_lst1_valid,
	input logic [15:0] i_lst_data,
	input logic        i_ctl_valid,
	input logic        i_ldp_valid,
	input logic [8:0]  i_ldp_data,
	input logic [6:0]  i_dir_lsbs,
	input logic        i_alu_valid,
	input logic        i_alu_sub,
	input logic        i_alu_shift16,
	input logic        i_alu_cout,
	input logic        i_shift_valid,
	input logic        i_interrupt_acknowledge,
	input logic        i_trap_maskable,
	input logic        i_int_req,
	input logic        i_nmi_req,
	input logic [15:0] o_st0,
	input logic [15:0] o_st1,
	input logic [15:0] o_direct_addr,
	input logic        o_int_take,
	input logic        o_exec_valid
);
	// Single domain, so clock and reset are given once
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);

	a_rsvd_read_one: assert property (((o_st0 & ST0_RSVD_MASK) == ST0_RSVD_MASK)
		&& ((o_st1 & ST1_RSVD_MASK) == ST1_RSVD_MASK)) else $error("reserved bit reads 0");
	a_lst_keeps_mask: assert property (i_lst0_valid && !i_interrupt_acknowledge && !i_trap_maskable
		&& !i_ctl_valid |=> $stable(o_st0[9])) else $error("load changed mask");
	a_page_only_load: assert property (!i_lst0_valid && !i_ldp_valid
		|=> $stable(o_st0[8:0])) else $error("page changed without load");
	a_ldp_sets_page: assert property (i_ldp_valid && !i_lst0_valid
		|=> o_st0[8:0] == $past(i_ldp_data)) else $error("page load wrong");
	a_direct_concat: assert property (1'b1
		|=> o_direct_addr == {o_st0[8:0], $past(i_dir_lsbs)}) else $error("direct address wrong");
	a_exec_four: assert property (i_fetch_valid |-> ##4 o_exec_valid)
		else $error("exec not four cycles after fetch");
	a_carry_add: assert property (i_alu_valid && !i_alu_sub && !i_alu_shift16
		&& !i_shift_valid && !i_ctl_valid && !i_lst1_valid |=> o_st1[9] == $past(i_alu_cout))
		else $error("add carry wrong");
	a_carry_s16_hold: assert property (i_alu_valid && i_alu_shift16 && !i_alu_cout
		&& !i_shift_valid && !i_ctl_valid && !i_lst1_valid |=> $stable(o_st1[9]))
		else $error("shifted carry changed");
	a_mask_blocks: assert property (i_int_req && o_st0[9] && !i_nmi_req
		|=> !o_int_take) else $error("masked interrupt taken");
	a_nmi_taken: assert property (i_nmi_req |=> o_int_take)
		else $error("non-maskable request not taken");
	a_ack_sets_mask: assert property (i_interrupt_acknowledge || i_trap_maskable |=> o_st0[9])
		else $error("mask not set by acknowledge");
	a_lst1_ptr_copy: assert property (i_lst1_valid && !i_ctl_valid
		|=> o_st0[15:13] == $past(i_lst_data[15:13])) else $error("pointer not copied");
endmodule

bind dspc_status_regs dspc_status_regs_chk i_dspc_status_regs_chk (.*);

// file: sim/testbench.sv
// Directed testbench for the core status block
`timescale 1ns/100ps
module testbench;
	import dspc_pkg::*;
	logic        i_clk = 0, i_rst = 1, i_fetch_valid = 0, i_lst0_valid = 0, i_lst1_valid = 0;
	logic        i_ctl_valid = 0, i_ctl_set = 0, i_arp_valid = 0, i_ldp_valid = 0;
	logic        i_alu_valid = 0, i_alu_sub = 0, i_alu_shift16 = 0, i_alu_cout = 0;
	logic        i_shift_valid = 0, i_shift_cout = 0, i_interrupt_acknowledge = 0, i_trap_maskable = 0;
	logic        i_int_req = 0, i_nmi_req = 0, i_multiplier_operand_register_load = 0, i_mpy_valid = 0;
	logic        i_mpy_unsigned = 0, i_push = 0, i_pop = 0;
	logic [3:0]  i_ctl_bit = 0, o_shift_count, o_bit_index;
	logic [2:0]  i_arp_data = 0;
	logic [8:0]  i_ldp_data = 0;
	logic [6:0]  i_dir_lsbs = 0;
	logic [15:0] i_lst_data = 0, i_multiplier_operand_register_data = 0, i_mpy_operand = 0, i_push_data = 0;
	logic [15:0] i_data_addr = 0, i_prog_addr = 0, o_st0, o_st1, o_direct_addr, o_multiplier_operand_register;
	logic [15:0] o_stack_top;
	dspc_stsel_e i_ctl_sel = SEL_ST0;
	logic [31:0] o_product, o_pscaled, prod;
	logic        o_int_take, o_b0_data_hit, o_b0_prog_hit, o_b1_hit, o_b2_hit, o_exec_valid;
	int          mismatches = 0, samples_checked = 0, cycles = 0;
	logic        exp_c;

	dspc_status_regs i_dspc_status_regs (.*);

	// Free-running 25 MHz clock
	always #20 i_clk = ~i_clk;

	// Cycle ceiling, so a stuck sequence still reaches the verdict
	always @(posedge i_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			mismatches = mismatches + 1;
			give_verdict();
		end
	end

	task give_verdict();
		$display("checked %0d, mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Strobes are raised after one edge and dropped after the next, so each is one cycle
	task at();
		@(posedge i_clk);
	endtask
	task go();
		@(posedge i_clk);
		{i_fetch_valid, i_lst0_valid, i_lst1_valid, i_ctl_valid, i_arp_valid, i_ldp_valid,
			i_alu_valid, i_shift_valid, i_interrupt_acknowledge, i_trap_maskable, i_int_req, i_nmi_req,
			i_multiplier_operand_register_load, i_mpy_valid, i_push, i_pop} <= '0;
		@(negedge i_clk);
	endtask
	task ctl(input logic s, input dspc_stsel_e sel, input logic [3:0] b);
		at();
		i_ctl_valid <= 1;
		i_ctl_set <= s;
		i_ctl_sel <= sel;
		i_ctl_bit <= b;
		go();
	endtask
	task load_status_instruction(input logic w, input logic [15:0] d);
		at();
		i_lst1_valid <= w;
		i_lst0_valid <= !w;
		i_lst_data <= d;
		go();
	endtask
	task aux_register_pointer(input logic [2:0] d);
		at();
		i_arp_valid <= 1;
		i_arp_data <= d;
		go();
	endtask
	task do_reset();
		at();
		i_rst <= 1;
		repeat (2) @(posedge i_clk);
		i_rst <= 0;
		@(negedge i_clk);
		check(o_st0, 16'h0600);
		check(o_st1, 16'h07FC);
	endtask

	initial
	begin
		do_reset();
		aux_register_pointer(3'd5);
		check(o_st0[15:13], 3'd5);
		check(o_st1[15:13], 3'd0);
		aux_register_pointer(3'd2);
		check(o_st1[15:13], 3'd5);
		load_status_instruction(1, 16'hC000);
		check(o_st1, 16'hC1EC);
		check(o_st0[15:13], 3'd6);
		load_status_instruction(0, 16'h0000);
		check(o_st0, 16'h0600);
		load_status_instruction(0, 16'hFFFF);
		check(o_st0, 16'hFFFF);
		check(o_st1[15:13], 3'd6);
		$display("pointer and load test done");
		// Mask: clear explicitly, then acknowledge and trap must set it again
		ctl(0, SEL_ST0, 4'd9);
		check(o_st0, 16'hFDFF);
		at();
		i_int_req <= 1;
		go();
		check(o_int_take, 1'b1);
		at();
		i_interrupt_acknowledge <= 1;
		go();
		check(o_st0[9], 1'b1);
		at();
		i_int_req <= 1;
		go();
		check(o_int_take, 1'b0);
		at();
		i_nmi_req <= 1;
		go();
		check(o_int_take, 1'b1);
		ctl(0, SEL_ST0, 4'd9);
		at();
		i_trap_maskable <= 1;
		go();
		check(o_st0[9], 1'b1);
		$display("mask test done");
		// Every add/sub, shift-16 and carry-out case from both prior carry values
		for (int k = 0; k < 16; k++)
		begin
			ctl(k[3], SEL_ST1, 4'd9);
			at();
			i_alu_valid <= 1;
			i_alu_sub <= k[2];
			i_alu_shift16 <= k[1];
			i_alu_cout <= k[0];
			go();
			exp_c = k[1] ? (k[0] ? !k[2] : k[3]) : (k[2] ? !k[0] : k[0]);
			check(o_st1[9], exp_c);
		end
		at();
		i_shift_valid <= 1;
		i_shift_cout <= !exp_c;
		go();
		check(o_st1[9], !exp_c);
		$display("carry test done");
		at();
		i_ldp_valid <= 1;
		i_ldp_data <= 9'h1A5;
		i_dir_lsbs <= 7'h3C;
		go();
		check(o_direct_addr, {9'h1A5, 7'h3C});
		// Product of -32766 and 2 through all four scaling modes
		at();
		i_multiplier_operand_register_load <= 1;
		i_multiplier_operand_register_data <= 16'h8002;
		go();
		check({o_shift_count, o_bit_index}, 8'h22);
		at();
		i_mpy_valid <= 1;
		i_mpy_operand <= 16'h0002;
		go();
		prod = 32'hFFFF_0004;
		check(o_product, prod);
		for (int m = 0; m < 4; m++)
		begin
			ctl(m[0], SEL_ST1, 4'd0);
			ctl(m[1], SEL_ST1, 4'd1);
			check(o_pscaled, m == 0 ? prod : m == 1 ? prod << 1 : m == 2 ? prod << 4 :
				32'($signed(prod) >>> 6));
		end
		at();
		i_mpy_valid <= 1;
		i_mpy_unsigned <= 1;
		go();
		check(o_product, 32'h0001_0004);
		$display("product test done");
		for (int i = 0; i < 8; i++)
		begin
			at();
			i_push <= 1;
			i_push_data <= 16'h1000 + 16'(i);
			go();
			check(o_stack_top, 16'h1000 + 16'(i));
		end
		for (int i = 6; i >= 0; i--)
		begin
			at();
			i_pop <= 1;
			go();
			check(o_stack_top, 16'h1000 + 16'(i));
		end
		$display("stack test done");
		at();
		i_data_addr <= 16'h0310;
		go();
		check(o_b1_hit, 1'b1);
		at();
		i_data_addr <= 16'h0070;
		go();
		check(o_b2_hit, 1'b1);
		ctl(1, SEL_ST1, 4'd12);
		at();
		i_prog_addr <= 16'hFF10;
		i_data_addr <= 16'h0200;
		go();
		check({o_b0_prog_hit, o_b0_data_hit}, 2'b10);
		ctl(0, SEL_ST1, 4'd12);
		check({o_b0_prog_hit, o_b0_data_hit}, 2'b01);
		at();
		i_fetch_valid <= 1;
		go();
		repeat (3) @(posedge i_clk);
		@(negedge i_clk);
		check(o_exec_valid, 1'b1);
		$display("decode and pipeline test done");
		do_reset();
		give_verdict();
	end
endmodule
